/* File: acqc_map.vh */
`ifndef ACQC_MAP_VH
`define ACQC_MAP_VH

// register byte offsets on the avalon slave
`define ACQC_OFS_CTRL_ZERO 8'h00
`define ACQC_OFS_CTRL_TWO 8'h04
`define ACQC_OFS_STATUS 8'h08
`define ACQC_OFS_ANA_SEL_LOW 8'h0C
`define ACQC_OFS_ANA_SEL_HIGH 8'h10
`define ACQC_OFS_PORT_A_DIR 8'h14
`define ACQC_OFS_PORT_E_DIR 8'h18
`define ACQC_OFS_PORT_A_READ 8'h1C
`define ACQC_OFS_PORT_E_READ 8'h20
`define ACQC_OFS_RESULT 8'h24
`define ACQC_OFS_CHAN_SEL 8'h28

// converter_ctrl_zero fields
`define ACQC_BIT_ENABLE 0
`define ACQC_BIT_GO 1
`define ACQC_BIT_CONTINUOUS 2

// converter_ctrl_two fields
`define ACQC_CLK_SEL_LSB 0
`define ACQC_CLK_SEL_MSB 2
`define ACQC_ACQ_SEL_LSB 3
`define ACQC_ACQ_SEL_MSB 6

// status fields
`define ACQC_BIT_BUSY 0
`define ACQC_BIT_DONE 1

// reset values
`define ACQC_RST_CTRL_ZERO 8'h00
`define ACQC_RST_CTRL_TWO 8'h00
`define ACQC_RST_ANA_SEL 9'h000
`define ACQC_RST_PORT_A_DIR 8'hFF
`define ACQC_RST_PORT_E_DIR 3'h7
`define ACQC_RST_CHAN_SEL 4'h0

// timing counts in conversion clock periods or system clocks
`define ACQC_CONV_TADS 4'hC
`define ACQC_POST_WAIT_TADS 4'h2
`define ACQC_INSTR_CYCLE_CLKS 4'h4
`define ACQC_RC_DIV_FOUR 7'h03

`endif

/* File: acqc_tad_gen.v */
`timescale 1ns/1ps
`default_nettype none

`include "acqc_map.vh"

module acqc_tad_gen
(
    // clock and synchronised reset
    input wire sys_clk,
    input wire rst_sync_n,
    // control
    input wire run,
    input wire [2:0] conv_clk_sel,
    input wire rc_tick,
    // one pulse per conversion clock period
    output reg tad_tick
);

    reg [6:0] div_q; // period counter
    reg [6:0] div_d;
    reg [6:0] term; // last count of the period
    reg src_event; // one count source event
    reg [2:0] exp_w; // power of two for oscillator dividers
    reg tick_d;

    // decode the select code into a source and a terminal count
    always @*
    begin
        exp_w = {sel_hi(conv_clk_sel), 1'b0} + {2'b00, conv_clk_sel[2]} + 3'h1;
        if (conv_clk_sel[1:0] == 2'b11)
        begin
            // internal rc source, divided by four or taken direct
            src_event = rc_tick;
            term = conv_clk_sel[2] ? 7'h00 : `ACQC_RC_DIV_FOUR;
        end
        else
        begin
            // oscillator source, 2 up to 64 periods
            src_event = 1'b1;
            term = (7'h01 << exp_w) - 7'h01;
        end
    end

    // low bits of the code, doubled at the call site
    function [1:0] sel_hi;
        input [2:0] sel;
        begin
            sel_hi = sel[1:0];
        end
    endfunction

    // count source events, wrap at the terminal count
    always @*
    begin
        div_d = div_q;
        tick_d = 1'b0;
        if (!run)
        begin
            div_d = 7'h00;
        end
        else if (src_event)
        begin
            if (div_q >= term)
            begin
                div_d = 7'h00;
                tick_d = 1'b1;
            end
            else
            begin
                div_d = div_q + 7'h01;
            end
        end
    end

    // divider state
    always @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            div_q <= 7'h00;
            tad_tick <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            tad_tick <= tick_d;
        end
    end

endmodule // acqc_tad_gen

`default_nettype wire

/* File: acqc_ctrl.v */
// Operation
// - select 0000: go ends sampling at once, then converts
// - acq_time_sel is bits 6:3, resets 0000
// - nonzero select samples then converts automatically
// - no status shows acquisition end or start
// - one conversion takes exactly 12 bit periods
// - clock select picks oscillator divider or rc
// - select 0000 delays start one instruction cycle
// - sleep conversions are single-shot only
// - port read returns 0 on analog pins
// - conversion ignores analog select and direction
// - output pins convert their driven digital level
// - select 0010 samples for 4 bit periods
// - after end or abort wait 2 periods, resample
// - clearing go aborts without done flag
`timescale 1ns/1ps
`default_nettype none

`include "acqc_map.vh"

module acqc_ctrl
(
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // avalon-mm slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // core state and internal rc oscillator
    input wire sleep_mode,
    input wire rc_osc_in,
    // port pins
    input wire [7:0] port_a_pin,
    input wire [2:0] port_e_pin,
    output reg [7:0] port_a_oe,
    output reg [2:0] port_e_oe,
    // analog front end
    input wire cmp_above,
    output reg sample_en,
    output reg [3:0] chan_sel,
    output reg [9:0] dac_code,
    output reg converter_done_flag
);

    // fsm states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_DELAY = 3'h1;
    localparam [2:0] ST_ACQ = 3'h2;
    localparam [2:0] ST_CONV = 3'h3;
    localparam [2:0] ST_WAIT = 3'h4;

    // reset synchroniser
    reg rst_s1_q;
    reg rst_sync_n;

    // pin synchronisers, three stages plus agreed value
    reg [11:0] pin_s1_q;
    reg [11:0] pin_s2_q;
    reg [11:0] pin_s3_q;
    reg [11:0] pin_q;
    reg rc_prev_q; // agreed rc level, last cycle
    reg rc_tick_q; // rising edge of agreed rc level

    // software registers
    reg enable_q;
    reg go_q;
    reg continuous_q;
    reg [2:0] conv_clk_sel_q;
    reg [3:0] acq_time_sel_q;
    reg [8:0] analog_sel_q;
    reg [7:0] port_a_direction_q;
    reg [2:0] port_e_direction_q;
    reg [9:0] result_q;

    // control state
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [4:0] cnt_q; // bit periods or clocks in a phase
    reg [4:0] cnt_d;
    reg [9:0] mask_q; // successive approximation trial bit
    reg [9:0] mask_d;
    reg [9:0] code_d;
    reg [9:0] result_d;
    reg go_clr; // hardware clears go
    reg done_set; // conversion completed
    reg tad_tick;

    // bus decode
    reg [31:0] rdata_d;
    wire bus_req = avs_read | avs_write;
    wire wr_now = avs_write & ~avs_waitrequest & avs_byteenable[0];
    wire [7:0] wd = avs_writedata[7:0];
    wire [7:0] port_a_read = pin_q[7:0] & ~{3'h0, analog_sel_q[4:0]};
    wire [2:0] port_e_read = pin_q[10:8] & ~analog_sel_q[7:5];

    // reset release through two flip-flops
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_sync_n <= rst_s1_q;
        end
    end

    // pins and rc clock pass three stages, a change counts when 2 and 3 agree
    always @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pin_s1_q <= 12'h000;
            pin_s2_q <= 12'h000;
            pin_s3_q <= 12'h000;
            pin_q <= 12'h000;
            rc_prev_q <= 1'b0;
            rc_tick_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= {rc_osc_in, port_e_pin, port_a_pin};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            // agreed bits follow, disagreeing bits hold
            pin_q <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
            rc_prev_q <= pin_q[11];
            rc_tick_q <= pin_q[11] & ~rc_prev_q;
        end
    end

    // conversion clock period generator
    acqc_tad_gen u_tad_gen
    (
        .sys_clk(sys_clk),
        .rst_sync_n(rst_sync_n),
        .run(state_q != ST_IDLE && state_q != ST_DELAY),
        .conv_clk_sel(conv_clk_sel_q),
        .rc_tick(rc_tick_q),
        .tad_tick(tad_tick)
    );

    // conversion sequencer
    always @*
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        mask_d = mask_q;
        code_d = dac_code;
        result_d = result_q;
        go_clr = 1'b0;
        done_set = 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                // conversion proceeds whatever the pin settings are
                if (enable_q && go_q)
                begin
                    cnt_d = 5'h00;
                    if (acq_time_sel_q == 4'h0)
                    begin
                        // sampling stops now, start held one instruction cycle
                        state_d = ST_DELAY;
                    end
                    else
                    begin
                        state_d = ST_ACQ;
                    end
                end
            end
            ST_DELAY:
            begin
                // one instruction cycle of system clocks
                if (!go_q || !enable_q)
                begin
                    state_d = ST_IDLE;
                end
                else if (cnt_q == {1'b0, `ACQC_INSTR_CYCLE_CLKS} - 5'h01)
                begin
                    state_d = ST_CONV;
                    cnt_d = 5'h00;
                    mask_d = 10'h200;
                    code_d = 10'h200;
                end
                else
                begin
                    cnt_d = cnt_q + 5'h01;
                end
            end
            ST_ACQ:
            begin
                // two bit periods per select step, 0010 gives 4
                if (!go_q || !enable_q)
                begin
                    state_d = ST_IDLE;
                end
                else if (tad_tick)
                begin
                    if (cnt_q == {acq_time_sel_q, 1'b0} - 5'h01)
                    begin
                        state_d = ST_CONV; // automatic start
                        cnt_d = 5'h00;
                        mask_d = 10'h200;
                        code_d = 10'h200;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 5'h01;
                    end
                end
            end
            ST_CONV:
            begin
                if (!go_q || !enable_q)
                begin
                    // abort, no done flag
                    state_d = ST_WAIT;
                    cnt_d = 5'h00;
                end
                else if (tad_tick)
                begin
                    if (cnt_q == {1'b0, `ACQC_CONV_TADS} - 5'h01)
                    begin
                        // twelfth period ends the conversion
                        result_d = dac_code;
                        done_set = 1'b1;
                        // sleep forces single-shot
                        go_clr = ~continuous_q | sleep_mode;
                        state_d = ST_WAIT;
                        cnt_d = 5'h00;
                    end
                    else
                    begin
                        if (cnt_q != 5'h00 && mask_q != 10'h000)
                        begin
                            // keep or drop the trial bit, try the next
                            code_d = (cmp_above ? dac_code : (dac_code & ~mask_q))
                                | (mask_q >> 1);
                            mask_d = mask_q >> 1;
                        end
                        cnt_d = cnt_q + 5'h01;
                    end
                end
            end
            ST_WAIT:
            begin
                // two bit periods before sampling resumes
                if (tad_tick)
                begin
                    if (cnt_q == {1'b0, `ACQC_POST_WAIT_TADS} - 5'h01)
                    begin
                        state_d = ST_IDLE;
                        cnt_d = 5'h00;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 5'h01;
                    end
                end
            end
            default:
            begin
                state_d = ST_IDLE;
                cnt_d = 5'h00;
            end
        endcase
    end

    // sequencer and front end registers
    always @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            mask_q <= 10'h000;
            dac_code <= 10'h000;
            result_q <= 10'h000;
            sample_en <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            mask_q <= mask_d;
            dac_code <= code_d;
            result_q <= result_d;
            // sampling while idle or acquiring
            sample_en <= enable_q & (state_d == ST_IDLE || state_d == ST_ACQ)
                & ~(state_d == ST_IDLE && go_q && acq_time_sel_q == 4'h0);
        end
    end

    // software registers; software writes to go win over the hardware clear
    always @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            enable_q <= 1'b0;
            go_q <= 1'b0;
            continuous_q <= 1'b0;
            conv_clk_sel_q <= 3'h0;
            acq_time_sel_q <= 4'h0;
            analog_sel_q <= `ACQC_RST_ANA_SEL;
            port_a_direction_q <= `ACQC_RST_PORT_A_DIR;
            port_e_direction_q <= `ACQC_RST_PORT_E_DIR;
            chan_sel <= `ACQC_RST_CHAN_SEL;
            converter_done_flag <= 1'b0;
        end
        else
        begin
            // hardware events first
            if (go_clr || !enable_q)
            begin
                go_q <= 1'b0;
            end
            if (wr_now)
            begin
                case (avs_address)
                    `ACQC_OFS_CTRL_ZERO:
                    begin
                        enable_q <= wd[`ACQC_BIT_ENABLE];
                        go_q <= wd[`ACQC_BIT_GO] & wd[`ACQC_BIT_ENABLE];
                        continuous_q <= wd[`ACQC_BIT_CONTINUOUS];
                    end
                    `ACQC_OFS_CTRL_TWO:
                    begin
                        conv_clk_sel_q <= wd[`ACQC_CLK_SEL_MSB:`ACQC_CLK_SEL_LSB];
                        acq_time_sel_q <= wd[`ACQC_ACQ_SEL_MSB:`ACQC_ACQ_SEL_LSB];
                    end
                    `ACQC_OFS_ANA_SEL_LOW: analog_sel_q[7:0] <= wd;
                    `ACQC_OFS_ANA_SEL_HIGH: analog_sel_q[8] <= wd[0];
                    `ACQC_OFS_PORT_A_DIR: port_a_direction_q <= wd;
                    `ACQC_OFS_PORT_E_DIR: port_e_direction_q <= wd[2:0];
                    `ACQC_OFS_CHAN_SEL: chan_sel <= wd[3:0];
                    default:
                    begin
                        // unmapped or read-only, ignored
                    end
                endcase
            end
            // done flag: write one clears, a new completion wins
            if (done_set)
            begin
                converter_done_flag <= 1'b1;
            end
            else if (wr_now && avs_address == `ACQC_OFS_STATUS && wd[`ACQC_BIT_DONE])
            begin
                converter_done_flag <= 1'b0;
            end
        end
    end

    // read mux; status shows go and done only, never the phase
    always @*
    begin
        rdata_d = 32'h00000000;
        case (avs_address)
            `ACQC_OFS_CTRL_ZERO: rdata_d[2:0] = {continuous_q, go_q, enable_q};
            `ACQC_OFS_CTRL_TWO: rdata_d[6:0] = {acq_time_sel_q, conv_clk_sel_q};
            `ACQC_OFS_STATUS: rdata_d[1:0] = {converter_done_flag, go_q};
            `ACQC_OFS_ANA_SEL_LOW: rdata_d[7:0] = analog_sel_q[7:0];
            `ACQC_OFS_ANA_SEL_HIGH: rdata_d[0] = analog_sel_q[8];
            `ACQC_OFS_PORT_A_DIR: rdata_d[7:0] = port_a_direction_q;
            `ACQC_OFS_PORT_E_DIR: rdata_d[2:0] = port_e_direction_q;
            `ACQC_OFS_PORT_A_READ: rdata_d[7:0] = port_a_read;
            `ACQC_OFS_PORT_E_READ: rdata_d[2:0] = port_e_read;
            `ACQC_OFS_RESULT: rdata_d[9:0] = result_q;
            `ACQC_OFS_CHAN_SEL: rdata_d[3:0] = chan_sel;
            default: rdata_d = 32'h00000000; // unmapped reads zero
        endcase
    end

    // one wait cycle per access, data captured while waitrequest is high
    always @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            port_a_oe <= 8'h00;
            port_e_oe <= 3'h0;
        end
        else
        begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (avs_read && avs_waitrequest)
            begin
                avs_readdata <= rdata_d;
            end
            // cleared direction bit drives the pin
            port_a_oe <= ~port_a_direction_q;
            port_e_oe <= ~port_e_direction_q;
        end
    end

endmodule // acqc_ctrl

`default_nettype wire

/* File: acqc_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module acqc_ctrl_chk
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // analog front end
    input wire logic sample_en,
    input wire logic [9:0] dac_code,
    input wire logic converter_done_flag
);
    // cycles since sampling last ended, saturating
    logic [15:0] since_q;
    logic [15:0] since_d;
    // previous sampling switch state
    logic sample_q;

    // next count: restart when sampling stops
    assign since_d = (sample_q && !sample_en) ? 16'h0001 :
                     (since_q == 16'hFFFF) ? since_q : since_q + 16'h0001;

    // count register, starts saturated so no false short count
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            since_q <= 16'hFFFF;
            sample_q <= 1'b0;
        end
        else
        begin
            since_q <= since_d;
            sample_q <= sample_en;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_wait_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("bus answer not one cycle after request");
    chk_unmapped_zero: assert property ((avs_read && !avs_waitrequest && avs_address == 8'h2C)
        |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_conv_min: assert property ($rose(converter_done_flag) |-> since_q >= 16'h0018)
        else $error("conversion shorter than twelve bit periods");
    chk_settle_code: assert property ($fell(sample_en) |-> ##[1:20] dac_code == 10'h200)
        else $error("trial code does not start at midscale");
    chk_post_wait: assert property ($rose(converter_done_flag) |-> !sample_en [*4])
        else $error("sampling resumed before the wait");
    chk_resample_auto: assert property ($rose(converter_done_flag) |-> ##[4:300] sample_en)
        else $error("sampling did not resume after conversion");
    chk_done_sticky: assert property ((converter_done_flag
        && !(avs_write && !avs_waitrequest && avs_address == 8'h08)) |=> converter_done_flag)
        else $error("done flag dropped without a clear");

    // main scenarios reached
    cov_done: cover property ($rose(converter_done_flag));
    cov_sample_end: cover property ($fell(sample_en));
    cov_resample: cover property ($rose(sample_en));
    cov_unmapped: cover property (avs_read && !avs_waitrequest && avs_address == 8'h2C);
endmodule // acqc_ctrl_chk

bind acqc_ctrl acqc_ctrl_chk acqc_ctrl_chk_i
(
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .sample_en(sample_en),
    .dac_code(dac_code),
    .converter_done_flag(converter_done_flag)
);

`default_nettype wire

/* File: acqc_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none

`include "acqc_map.vh"

module acqc_ctrl_bench;
    // design inputs
    logic sys_clk, rst_n, avs_read, avs_write, sleep_mode, rc_osc_in, cmp_above;
    logic [7:0] avs_address, port_a_pin;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [2:0] port_e_pin;
    // design outputs
    logic [31:0] avs_readdata;
    logic avs_waitrequest, sample_en, converter_done_flag;
    logic [7:0] port_a_oe;
    logic [2:0] port_e_oe;
    logic [3:0] chan_sel;
    logic [9:0] dac_code;
    // bench state
    logic [2:0] rc_div;
    logic [31:0] rd;
    integer miscompares, tests_run, i, tf, td, n, base, f0;
    localparam logic [9:0] ANA = 10'h2A5; // analog level on the pin
    logic [2:0] codes [6] = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110};
    integer tads [6] = '{2, 4, 8, 16, 32, 64};
    logic [3:0] acqs [3] = '{4'h1, 4'h2, 4'h4};

    acqc_ctrl acqc_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sleep_mode(sleep_mode), .rc_osc_in(rc_osc_in),
        .port_a_pin(port_a_pin), .port_e_pin(port_e_pin), .port_a_oe(port_a_oe),
        .port_e_oe(port_e_oe), .cmp_above(cmp_above), .sample_en(sample_en),
        .chan_sel(chan_sel), .dac_code(dac_code), .converter_done_flag(converter_done_flag));

    // 25 mhz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // rc source at one eighth of the clock, comparator against fixed level
    always @(posedge sys_clk)
    begin
        rc_div <= rc_div + 3'h1;
        rc_osc_in <= rc_div[2];
        cmp_above <= (ANA >= dac_code);
    end

    // verdict and end of run
    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, miscompares);
            if (miscompares == 0 && tests_run > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    // compare seen against expected
    task check(input string what, input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp)
            begin
                miscompares = miscompares + 1;
                $display("wrong value %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    // one bus access, held until waitrequest is sampled low
    task bus(input logic wr, input [7:0] a, input [31:0] d);
        integer k;
        begin
            avs_address <= a;
            avs_writedata <= d;
            if (wr) avs_write <= 1'b1;
            else avs_read <= 1'b1;
            k = 0;
            do begin @(posedge sys_clk); k = k + 1; end
            while (avs_waitrequest !== 1'b0 && k < 50);
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            if (k >= 50)
            begin
                miscompares = miscompares + 1;
                give_verdict;
            end
            @(posedge sys_clk);
        end
    endtask

    // wait for sampling switch (s=1) or done flag (s=0) to reach v
    task wait_for(input logic s, input logic v, output integer c);
        begin
            c = 0;
            while (((s ? sample_en : converter_done_flag) !== v) && c < 2000)
            begin
                @(posedge sys_clk);
                c = c + 1;
            end
            if (c >= 2000)
            begin
                miscompares = miscompares + 1;
                give_verdict;
            end
        end
    endtask

    // one single-shot conversion with acq and clock select
    task conv(input [6:0] cfg);
        begin
            bus(1'b1, `ACQC_OFS_STATUS, 32'h2);
            bus(1'b1, `ACQC_OFS_CTRL_TWO, {25'h0, cfg});
            // continuous asked for while asleep, must still run once
            bus(1'b1, `ACQC_OFS_CTRL_ZERO, {29'h0, sleep_mode, 2'b11});
            wait_for(1'b1, 1'b0, tf);
            wait_for(1'b0, 1'b1, n);
            td = tf + n;
            wait_for(1'b1, 1'b1, n);
            bus(1'b0, `ACQC_OFS_RESULT, 32'h0);
            check("result", rd, {22'h0, ANA});
        end
    endtask

    // main sequence
    initial
    begin
        {avs_read, avs_write, sleep_mode, rc_osc_in, cmp_above} = 5'h00;
        {avs_address, avs_writedata, rc_div, rd} = 0;
        {avs_byteenable, port_a_pin, port_e_pin} = {4'hF, 8'hFF, 3'h7};
        {miscompares, tests_run, base, f0} = 0;
        rst_n = 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        bus(1'b0, `ACQC_OFS_CTRL_TWO, 32'h0);
        check("ctrl two reset", rd, 32'h0);
        bus(1'b0, 8'h2C, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(1'b0, `ACQC_OFS_PORT_A_DIR, 32'h0);
        check("direction reset", rd, 32'hFF);
        check("oe reset", {21'h0, port_e_oe, port_a_oe}, 32'h0);
        bus(1'b1, `ACQC_OFS_CTRL_TWO, 32'h78);
        bus(1'b0, `ACQC_OFS_CTRL_TWO, 32'h0);
        check("acq field", rd, 32'h78);
        // write with low byte disabled is ignored
        avs_byteenable <= 4'hE;
        bus(1'b1, `ACQC_OFS_CTRL_TWO, 32'h0);
        avs_byteenable <= 4'hF;
        bus(1'b0, `ACQC_OFS_CTRL_TWO, 32'h0);
        check("masked write", rd, 32'h78);
        // analog pins read as low
        bus(1'b1, `ACQC_OFS_ANA_SEL_LOW, 32'hB5);
        repeat (4) @(posedge sys_clk);
        bus(1'b0, `ACQC_OFS_PORT_A_READ, 32'h0);
        check("port a read", rd, 32'hEA);
        bus(1'b0, `ACQC_OFS_PORT_E_READ, 32'h0);
        check("port e read", rd, 32'h2);
        bus(1'b1, `ACQC_OFS_CTRL_ZERO, 32'h1);
        // channel change, then sampled long enough before converting
        bus(1'b1, `ACQC_OFS_CHAN_SEL, 32'h5);
        check("channel", {28'h0, chan_sel}, 32'h5);
        repeat (20) @(posedge sys_clk);
        // oscillator dividers, outputs driven from the fourth run on
        for (i = 0; i < 6; i = i + 1)
        begin
            if (i == 3) bus(1'b1, `ACQC_OFS_PORT_A_DIR, 32'h0);
            conv({4'h0, codes[i]});
            if (i == 0) {base, f0} = {td, tf};
            check("bit period span", td - base, 12 * (tads[i] - 2));
            if (i == 3) check("pin drive", {24'h0, port_a_oe}, 32'hFF);
        end
        check("no acquisition", {31'h0, f0 <= 2}, 32'h1);
        // rc sources, second one while asleep
        conv(7'h03);
        check("rc quarter", {31'h0, (td - base > 340) && (td - base < 380)}, 32'h1);
        sleep_mode <= 1'b1; // sleep forces the next conversion single-shot
        conv(7'h07); // rc clock chosen while asleep
        check("rc direct", {31'h0, (td - base > 60) && (td - base < 84)}, 32'h1);
        bus(1'b0, `ACQC_OFS_STATUS, 32'h0);
        check("sleep status", rd, 32'h2);
        sleep_mode <= 1'b0;
        // programmed acquisition lengths
        for (i = 0; i < 3; i = i + 1)
        begin
            conv({acqs[i], 3'b101}); // oscillator divider of 16 clocks per bit period
            if (i == 0) base = tf;
            check("acq span", tf - base, 32 * (acqs[i] - 1));
        end
        // done cleared so the status reads show go alone
        bus(1'b1, `ACQC_OFS_STATUS, 32'h2);
        // status silent during acquisition, then cancel
        bus(1'b1, `ACQC_OFS_CTRL_TWO, 32'h7E);
        bus(1'b1, `ACQC_OFS_CTRL_ZERO, 32'h3);
        bus(1'b0, `ACQC_OFS_STATUS, 32'h0);
        check("status in acq", rd, 32'h1);
        check("still sampling", {31'h0, sample_en}, 32'h1);
        bus(1'b1, `ACQC_OFS_CTRL_ZERO, 32'h1);
        // abort in mid conversion
        bus(1'b1, `ACQC_OFS_CTRL_TWO, 32'h06);
        bus(1'b1, `ACQC_OFS_CTRL_ZERO, 32'h3);
        wait_for(1'b1, 1'b0, tf);
        repeat (200) @(posedge sys_clk);
        bus(1'b0, `ACQC_OFS_STATUS, 32'h0);
        check("status in conv", rd, 32'h1);
        bus(1'b1, `ACQC_OFS_CTRL_ZERO, 32'h1);
        wait_for(1'b1, 1'b1, n);
        check("abort wait", {31'h0, (n > 60) && (n < 140)}, 32'h1);
        repeat (800) @(posedge sys_clk);
        check("abort no done", {31'h0, converter_done_flag}, 32'h0);
        bus(1'b0, `ACQC_OFS_RESULT, 32'h0);
        check("abort result", rd, {22'h0, ANA});
        give_verdict;
    end
endmodule // acqc_ctrl_bench

`default_nettype wire
